// ===== core/gpio_port_block.sv
// gpio port block: six bidirectional ports, pull-ups, falling-edge wake-up
// assumes: core drives a simple strobe port; pins resolved by pad logic
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_map.svh"
module gpio_port_block (
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // register port
  input wire logic [4:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // power control
  input wire logic halt_i,
  output logic sleep_o,
  output logic wake_o,
  // pins, six ports of eight
  input wire logic [47:0] pin_i,
  output logic [47:0] pin_o,
  output logic [47:0] pin_oen_o,
  output logic [47:0] pullup_o
);
  gpio_port_pkg::reg_req_t req;
  gpio_port_pkg::byte_t data_ff [6];
  gpio_port_pkg::byte_t dir_ff [6];
  gpio_port_pkg::byte_t pu_ff [6];
  gpio_port_pkg::byte_t nxt_data [6];
  gpio_port_pkg::byte_t nxt_dir [6];
  gpio_port_pkg::byte_t nxt_pu [6];
  gpio_port_pkg::byte_t wk_a_ff, wk_c_ff, nxt_wk_a, nxt_wk_c;
  gpio_port_pkg::byte_t rdata_ff, nxt_rdata;
  gpio_port_pkg::power_state_t pwr_ff, nxt_pwr;
  logic [47:0] level;
  logic [15:0] wk_pins;
  logic [15:0] fall_seen;
  logic [15:0] fall_s1_ff, fall_s2_ff, fall_s3_ff;
  logic [15:0] nxt_fall_s1, nxt_fall_s2, nxt_fall_s3;
  logic fall_agree;
  logic fall_clr_ff, nxt_fall_clr;
  logic wake_ff, nxt_wake;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // four flops per pin (three stages and a level flop) before the read path uses it
  for (genvar p = 0; p < 6; p++) begin : g_sync
    pin_sync pin_sync_inst (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .pin_i(pin_i[p*8 +: 8]),
      .level_o(level[p*8 +: 8])
    );
  end

  function automatic gpio_port_pkg::byte_t impl_dir(input int p);
    // port f has two pins only
    impl_dir = (p == 5) ? `PORT_F_MASK : 8'hff;
  endfunction : impl_dir

  function automatic gpio_port_pkg::byte_t impl_pu(input int p);
    // no pull-up on top pin of A
    impl_pu = (p == 0) ? `PORT_A_PU_MASK : impl_dir(p);
  endfunction : impl_pu

  // register writes
  always_comb begin
    for (int p = 0; p < 6; p++) begin
      nxt_data[p] = data_ff[p];
      nxt_dir[p] = dir_ff[p];
      nxt_pu[p] = pu_ff[p];
      if (req.wr && req.addr == 5'(`PORT_DATA_A + p))
        nxt_data[p] = req.wdata & impl_dir(p);
      if (req.wr && req.addr == 5'(`PORT_DIR_A + p))
        nxt_dir[p] = req.wdata & impl_dir(p);
      if (req.wr && req.addr == 5'(`PORT_PU_A + p))
        nxt_pu[p] = req.wdata & impl_pu(p);
    end
    nxt_wk_a = wk_a_ff;
    nxt_wk_c = wk_c_ff;
    if (req.wr && req.addr == `PORT_A_WAKE) nxt_wk_a = req.wdata;
    if (req.wr && req.addr == `PORT_C_WAKE) nxt_wk_c = req.wdata;
  end

  // read path
  always_comb begin
    nxt_rdata = 8'h00;
    for (int p = 0; p < 6; p++) begin
      // mux pin or latch at read
      if (req.addr == 5'(`PORT_DATA_A + p))
        nxt_rdata = ((level[p*8 +: 8] & dir_ff[p])
                   | (data_ff[p] & ~dir_ff[p])) & impl_dir(p);
      if (req.addr == 5'(`PORT_DIR_A + p)) nxt_rdata = dir_ff[p];
      if (req.addr == 5'(`PORT_PU_A + p)) nxt_rdata = pu_ff[p];
    end
    if (req.addr == `PORT_A_WAKE) nxt_rdata = wk_a_ff;
    if (req.addr == `PORT_C_WAKE) nxt_rdata = wk_c_ff;
    if (req.addr == `PORT_SLEEP_STAT)
      nxt_rdata = {7'h00, pwr_ff == gpio_port_pkg::ASLEEP};
    if (!req.rd) nxt_rdata = 8'h00;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      for (int p = 0; p < 6; p++) begin
        data_ff[p] <= (p == 5) ? `PORT_F_MASK : `PORT_DATA_RST;
        dir_ff[p] <= (p == 5) ? `PORT_F_DIR_RST : `PORT_DIR_RST;
        pu_ff[p] <= `PORT_PU_RST;
      end
      wk_a_ff <= `PORT_WAKE_RST;
      wk_c_ff <= `PORT_WAKE_RST;
      rdata_ff <= 8'h00;
    end else if (ce_i) begin
      for (int p = 0; p < 6; p++) begin
        data_ff[p] <= nxt_data[p];
        dir_ff[p] <= nxt_dir[p];
        pu_ff[p] <= nxt_pu[p];
      end
      wk_a_ff <= nxt_wk_a;
      wk_c_ff <= nxt_wk_c;
      rdata_ff <= nxt_rdata;
    end
  end

  // pad drive
  always_comb begin
    for (int p = 0; p < 6; p++) begin
      pin_o[p*8 +: 8] = data_ff[p];
      pin_oen_o[p*8 +: 8] = dir_ff[p] | ~impl_dir(p);
      pullup_o[p*8 +: 8] = pu_ff[p] & dir_ff[p];
    end
  end

  // wake pins: port A then port C
  assign wk_pins = {pin_i[23:16], pin_i[7:0]};

  // async capture, clock may be stopped
  for (genvar w = 0; w < 16; w++) begin : g_fall
    logic en;
    logic seen_ff;
    assign en = (w < 8) ? wk_a_ff[w % 8] : wk_c_ff[w % 8];
    always_ff @(negedge wk_pins[w] or posedge fall_clr_ff) begin
      if (fall_clr_ff) seen_ff <= 1'b0;
      else seen_ff <= 1'b1;
    end
    assign fall_seen[w] = seen_ff & en;
  end

  // sleep control
  // a change counts once stages two and three agree
  assign fall_agree = |(fall_s2_ff & fall_s3_ff);

  always_comb begin
    nxt_pwr = pwr_ff;
    nxt_wake = 1'b0;
    nxt_fall_clr = 1'b0;
    // stages flushed while running: a stale fall cannot wake
    nxt_fall_s1 = 16'h0000;
    nxt_fall_s2 = 16'h0000;
    nxt_fall_s3 = 16'h0000;
    unique case (pwr_ff)
      gpio_port_pkg::RUNNING: begin
        // catchers held clear, released on the halt edge
        nxt_fall_clr = !halt_i;
        if (halt_i) nxt_pwr = gpio_port_pkg::ASLEEP;
      end
      gpio_port_pkg::ASLEEP: begin
        nxt_fall_s1 = fall_seen;
        nxt_fall_s2 = fall_s1_ff;
        nxt_fall_s3 = fall_s2_ff;
        if (fall_agree) begin
          nxt_pwr = gpio_port_pkg::RUNNING;
          nxt_wake = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      pwr_ff <= gpio_port_pkg::RUNNING;
      wake_ff <= 1'b0;
      fall_clr_ff <= 1'b1;
      fall_s1_ff <= 16'h0000;
      fall_s2_ff <= 16'h0000;
      fall_s3_ff <= 16'h0000;
    end else if (ce_i) begin
      pwr_ff <= nxt_pwr;
      wake_ff <= nxt_wake;
      fall_clr_ff <= nxt_fall_clr;
      fall_s1_ff <= nxt_fall_s1;
      fall_s2_ff <= nxt_fall_s2;
      fall_s3_ff <= nxt_fall_s3;
    end
  end

  assign rdata_o = rdata_ff;
  assign sleep_o = (pwr_ff == gpio_port_pkg::ASLEEP);
  assign wake_o = wake_ff;

  property p_dir_reset;
    @(posedge sys_clk_i) $rose(rstn_i) |-> dir_ff[0] == `PORT_DIR_RST;
  endproperty
  a_dir_reset: assert property (p_dir_reset)
    else $error("direction not all ones after reset");

  property p_out_drive;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      !dir_ff[1][0] |-> !pin_oen_o[8] && pin_o[8] == data_ff[1][0];
  endproperty
  a_out_drive: assert property (p_out_drive)
    else $error("output pin not driven from latch");

  property p_in_float;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      dir_ff[2][3] |-> pin_oen_o[19];
  endproperty
  a_in_float: assert property (p_in_float)
    else $error("input pin being driven");

  property p_a7_pu;
    @(posedge sys_clk_i) disable iff (!rstn_i) !pullup_o[`PORT_TOP_PIN];
  endproperty
  a_a7_pu: assert property (p_a7_pu)
    else $error("pull-up on port A top pin");

  property p_pu_input;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      pullup_o[9] |-> dir_ff[1][1] && pu_ff[1][1];
  endproperty
  a_pu_input: assert property (p_pu_input)
    else $error("pull-up on output pin");

  property p_f_unimpl;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      ce_i && rd_i && addr_i == `PORT_DIR_A + 5'h05 |=> rdata_o[7:2] == 6'h00;
  endproperty
  a_f_unimpl: assert property (p_f_unimpl)
    else $error("unimplemented bits read nonzero");

  property p_latch_hold;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      !(wr_i && addr_i == `PORT_DATA_A) |=> $stable(data_ff[0]);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latch changed without write");

  property p_out_read;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      ce_i && rd_i && addr_i == `PORT_DATA_A && dir_ff[0] == 8'h00
      |=> rdata_o == $past(data_ff[0]);
  endproperty
  a_out_read: assert property (p_out_read)
    else $error("output read not latch value");

  property p_sleep_entry;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      ce_i && !sleep_o && halt_i |=> sleep_o;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("halt did not enter sleep");

  property p_wake_cause;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      wake_o |-> $past(sleep_o) && $past(fall_agree);
  endproperty
  a_wake_cause: assert property (p_wake_cause)
    else $error("wake without enabled falling edge");

  property p_in_read;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      ce_i && rd_i && addr_i == `PORT_DATA_A + 5'h01
      |=> ((rdata_o ^ $past(level[15:8])) & $past(dir_ff[1])) == 8'h00;
  endproperty
  a_in_read: assert property (p_in_read)
    else $error("input pin read not pin level");

  property p_dir_write;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      ce_i && wr_i && addr_i == `PORT_DIR_A + 5'h02
      |=> dir_ff[2] == $past(wdata_i);
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("direction write not taken");

  property p_data_reset;
    @(posedge sys_clk_i) $rose(rstn_i) |-> data_ff[0] == `PORT_DATA_RST;
  endproperty
  a_data_reset: assert property (p_data_reset)
    else $error("data latch not all ones after reset");

  property p_sleep_hold;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      ce_i && sleep_o && !fall_agree |=> sleep_o;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("left sleep without enabled fall");

  property p_wake_exit;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      ce_i && sleep_o && fall_agree |=> !sleep_o && wake_o;
  endproperty
  a_wake_exit: assert property (p_wake_exit)
    else $error("enabled fall did not wake");

  property p_wake_pulse;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      ce_i && wake_o |=> !wake_o;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse)
    else $error("wake pulse longer than one cycle");

  property p_unmapped;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      ce_i && rd_i && addr_i > `PORT_SLEEP_STAT |=> rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped index read nonzero");
endmodule : gpio_port_block
`default_nettype wire

// ===== core/gpio_port_map.svh
// gpio port block: register offsets, field positions, reset values
// assumes: included by the port block only, word index offsets
`ifndef GPIO_PORT_MAP_SVH
`define GPIO_PORT_MAP_SVH
`define PORT_DATA_A 5'h00
`define PORT_DIR_A 5'h06
`define PORT_PU_A 5'h0c
`define PORT_A_WAKE 5'h12
`define PORT_C_WAKE 5'h13
`define PORT_SLEEP_STAT 5'h14
`define PORT_F_MASK 8'h03
`define PORT_A_PU_MASK 8'h7f
`define PORT_DATA_RST 8'hff
`define PORT_DIR_RST 8'hff
`define PORT_F_DIR_RST 8'h03
`define PORT_PU_RST 8'h00
`define PORT_WAKE_RST 8'h00
`define PORT_TOP_PIN 7
`endif

// ===== core/gpio_port_pkg.sv
// gpio port block: shared types
// assumes: constants come from gpio_port_map.svh
`default_nettype none
package gpio_port_pkg;
  typedef logic [7:0] byte_t;
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef enum logic [0:0] {RUNNING, ASLEEP} power_state_t;
endpackage : gpio_port_pkg
`default_nettype wire

// ===== core/pin_sync.sv
// gpio port block: three-stage synchroniser for a byte of pins
// assumes: pins are asynchronous to sys_clk_i
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // pins
  input wire logic [7:0] pin_i,
  output logic [7:0] level_o
);
  logic [7:0] s1_ff, s2_ff, s3_ff, lvl_ff;
  logic [7:0] nxt_lvl;
  // a change counts once stages two and three agree
  always_comb begin
    nxt_lvl = lvl_ff;
    for (int i = 0; i < 8; i++) begin
      if (s2_ff[i] == s3_ff[i]) nxt_lvl[i] = s3_ff[i];
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      s1_ff <= 8'hff;
      s2_ff <= 8'hff;
      s3_ff <= 8'hff;
      lvl_ff <= 8'hff;
    end else if (ce_i) begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end
  assign level_o = lvl_ff;
endmodule : pin_sync
`default_nettype wire

// ===== test/pin_partner.sv
// pin partner: outside circuits on the six port pin groups
// assumes: bench sets drive, device gives latch, enable, pull-up
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  // clock
  input wire logic sys_clk_i,
  // device side
  input wire logic [47:0] dev_out_i,
  input wire logic [47:0] dev_oen_i,
  input wire logic [47:0] pullup_i,
  // bench control
  input wire logic [47:0] drv_en_i,
  input wire logic [47:0] drv_val_i,
  input wire logic clash_i,
  // resolved pins
  output logic [47:0] level_o
);
  logic [47:0] alt_ff = 48'h5555_5555_5555;
  // floating pins wander, never a steady level
  always @(posedge sys_clk_i) begin
    alt_ff <= ~alt_ff;
  end
  always_comb begin
    for (int b = 0; b < 48; b++) begin
      if (!dev_oen_i[b] && !clash_i) level_o[b] = dev_out_i[b];
      else if (drv_en_i[b]) level_o[b] = drv_val_i[b];
      else if (pullup_i[b]) level_o[b] = 1'b1;
      else level_o[b] = alt_ff[b];
    end
  end
endmodule : pin_partner
`default_nettype wire

// ===== test/tb_gpio_port_block.sv
// bench for the port block: registers, pins, sleep and wake
// assumes: pin_partner resolves the pins, one 125 mhz clock
`timescale 1ns/1ps
`default_nettype none
module tb_gpio_port_block;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [4:0] addr_i = 5'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic halt_i = 1'b0;
  logic ce = 1'b1;
  logic [47:0] drv_en = 48'h0;
  logic [47:0] drv_val = 48'h0;
  logic clash = 1'b0;
  logic [7:0] rdata_o;
  logic sleep_o;
  logic wake_o;
  logic [47:0] pin_i, pin_o, pin_oen_o, pullup_o;
  logic rd_d = 1'b0;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h9a2f6dbf;
  int miscompares = 0;
  int cmp_count = 0;

  always #4 sys_clk_i = ~sys_clk_i;

  gpio_port_block gpio_port_block_inst (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .ce_i(ce),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .halt_i(halt_i), .sleep_o(sleep_o),
    .wake_o(wake_o), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oen_o(pin_oen_o), .pullup_o(pullup_o));
  pin_partner pin_partner_inst (
    .sys_clk_i(sys_clk_i), .dev_out_i(pin_o), .dev_oen_i(pin_oen_o),
    .pullup_i(pullup_o), .drv_en_i(drv_en), .drv_val_i(drv_val),
    .clash_i(clash), .level_o(pin_i));

  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : xs
  function automatic logic [7:0] msk(input int i);
    if (i == 11 || i == 17) return 8'h03;
    if (i == 12) return 8'h7f;
    return (i < 20) ? 8'hff : 8'h00;
  endfunction : msk
  function automatic logic [7:0] rst_val(input int i);
    if (i == 11) return 8'h03;
    return (i < 12) ? 8'hff : 8'h00;
  endfunction : rst_val

  task automatic cmp8(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp8
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : tick
  task automatic wr(input int a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a[4:0];
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input int a, input logic [7:0] e);
    @(posedge sys_clk_i);
    addr_i <= a[4:0];
    rd_i <= 1'b1;
    exp_q.push_back(e);
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
  endtask : rd
  task automatic do_reset();
    rstn_i <= 1'b0;
    tick(5);
    rstn_i <= 1'b1;
  endtask : do_reset
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  // read data stands only in the cycle after the strobe
  always @(posedge sys_clk_i) begin
    if (rd_d) begin
      if (exp_q.size() == 0) cmp8("read_extra", 8'h00, 8'hff);
      else cmp8("read_data", exp_q.pop_front(), rdata_o);
    end
    rd_d <= rd_i;
  end

  initial begin
    tick(40000);
    miscompares++;
    complete_run();
  end

  initial begin
    logic [7:0] d, r, v, u;
    int k, j;
    do_reset();
    for (int i = 6; i < 32; i++) rd(i, rst_val(i));
    for (int i = 6; i < 32; i++) begin
      v = xs();
      if (i != 20) wr(i, v);
      rd(i, v & msk(i));
    end
    // second reset in mid-run
    do_reset();
    rd(6, 8'hff);
    rd(12, 8'h00);
    // clock enable low: the write must not land
    ce <= 1'b0;
    wr(7, 8'h00);
    ce <= 1'b1;
    rd(7, 8'hff);
    wr(11, 8'h00);
    tick(1);
    cmp8("oen_f", 8'hfc, pin_oen_o[47:40]);
    clash <= 1'b1;
    drv_en <= '1;
    for (int p = 0; p < 5; p++) begin
      d = xs();
      r = xs();
      v = xs();
      u = xs();
      drv_val[p*8 +: 8] <= v;
      wr(p, d);
      wr(6 + p, r);
      wr(12 + p, u);
      u = u & r & ((p == 0) ? 8'h7f : 8'hff);
      tick(8);
      rd(p, (d & ~r) | (v & r));
      cmp8("pin_out", d, pin_o[p*8 +: 8]);
      cmp8("pin_oen", r, pin_oen_o[p*8 +: 8]);
      cmp8("pullup", u, pullup_o[p*8 +: 8]);
    end
    clash <= 1'b0;
    drv_val <= '1;
    wr(0, 8'h5a);
    wr(6, 8'h00);
    rd(0, 8'h5a);
    wr(6, 8'hff);
    wr(8, 8'hff);
    for (int q = 0; q < 2; q++) begin
      k = xs() % 8;
      j = (k + 1) % 8;
      wr(18 + q, 8'h01 << k);
      wr(19 - q, 8'h00);
      tick(8);
      halt_i <= 1'b1;
      tick(1);
      halt_i <= 1'b0;
      tick(1);
      cmp8("sleep", 8'h01, {7'h0, sleep_o});
      drv_val[q*16 + j] <= 1'b0;
      tick(12);
      cmp8("sleep_held", 8'h01, {7'h0, sleep_o});
      rd(20, 8'h01);
      drv_val[q*16 + k] <= 1'b0;
      u = 8'h00;
      for (int n = 0; n < 20 && u == 8'h00; n++) begin
        tick(1);
        u = {7'h0, wake_o};
      end
      cmp8("wake", 8'h01, u);
      tick(1);
      cmp8("awake", 8'h00, {7'h0, sleep_o});
      drv_val <= '1;
      tick(8);
    end
    tick(4);
    complete_run();
  end
endmodule : tb_gpio_port_block
`default_nettype wire
